// ==== shared/led_sup_pkg.sv ====
// constants, input indices and state encoding for the led driver supervisor
package led_sup_pkg;
  localparam int CLK_HZ = 32'h0262_5a00;
  localparam int CLK_PERIOD_NS = 32'h0000_0019;
  localparam int RECOVERY_S = 32'h0000_0004;
  localparam int REC_CYCLES = RECOVERY_S * CLK_HZ;
  localparam int AUX_SHORT_MS = 32'h0000_005a;
  localparam int AUX_CYCLES = (CLK_HZ / 32'h0000_03e8) * AUX_SHORT_MS;
  localparam int TIMEOUT_NS = 32'h0000_1964;
  localparam int TIMO_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int FOLD_STEP_CYCLES = 32'h0000_0100;
  localparam int REC_W = 28;
  localparam int AUX_W = 22;
  localparam int TIMO_W = 9;
  localparam int FOLD_W = 8;
  localparam logic [2:0] OC_LIMIT = 3'h4;
  localparam logic [3:0] REF_FULL = 4'hf;
  localparam logic [3:0] REF_MIN = 4'h8;
  localparam logic [2:0] VALLEY_LOW_LINE = 3'h1;
  localparam logic [2:0] VALLEY_HIGH_LINE = 3'h2;
  localparam logic [2:0] VALLEY_LIGHT_ADD = 3'h1;
  // comparator input indices
  localparam int NIN = 18;
  localparam int I_PEAK = 0;
  localparam int I_OC = 1;
  localparam int I_SETP = 2;
  localparam int I_VLOW = 3;
  localparam int I_VSHORT = 4;
  localparam int I_VCCOVP = 5;
  localparam int I_CSFLT = 6;
  localparam int I_OTP = 7;
  localparam int I_SDOVP = 8;
  localparam int I_HOT = 9;
  localparam int I_FOLD = 10;
  localparam int I_DIMZ = 11;
  localparam int I_DIMF = 12;
  localparam int I_VCCON = 13;
  localparam int I_VCCOK = 14;
  localparam int I_LINEH = 15;
  localparam int I_LIGHT = 16;
  localparam int I_SINK = 17;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_WAIT = 3'h1,
    ST_ON = 3'h3,
    ST_RECOVER = 3'h2,
    ST_LATCH = 3'h6
  } state_t;
endpackage : led_sup_pkg

// ==== rtl/led_driver_fault_startup_supervisor.sv ====
// start-up, valley and fault supervisor that sequences the gate drive
// Notes on behaviour
// RL1: peak limit trip ends on-time at once
// RL2: four consecutive 150% cycles stop switching
// RL3: faults latch off or recover after 4 s
// RL4: no valley-sense above 1 V for 90 ms faults
// RL5: aux short latches or forces 4 s recovery
// RL6: shorted load hiccups until aux short trips
// RL7: supply overvoltage stops, restarts after 4 s
// RL8: current-sense grounded or open stops operation
// RL9: shutdown pin low or high stops device
// RL10: foldback lowers reference gradually, floor 50%
// RL11: full reference unless foldback or dimmed
// RL12: on-time ends at control setpoint trip
// RL13: major fault grounds comp, lockout does not
// RL14: comp node grounded while device off
// RL15: start boost source on until amp sinks
// RL16: retry after lockout keeps comp level
// RL17: turn on at valley, later at light load
// RL18: chosen valley held until line/light-load change
// RL19: 6.5 us timeout makes substitute valley pulse
// RL20: aux short timer cleared only by short level; the code also clears it on entering ST_RECOVER or ST_LATCH
// RL21: first valley low line, second high line
// RL22: gate off while dimming below zero level
// RL23: timers on clock, latch cleared by reset only
// RL24: version input picks latch or auto-recovery
`timescale 1ns/1ps
module led_driver_fault_startup_supervisor #(
  parameter int REC_CYCLES = led_sup_pkg::REC_CYCLES,
  parameter int AUX_CYCLES = led_sup_pkg::AUX_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic versionLatchIn,
  input wire logic peakLimitIn,
  input wire logic overCurrentIn,
  input wire logic setpointTripIn,
  input wire logic valleyLowIn,
  input wire logic valleyShortIn,
  input wire logic supplyOvpIn,
  input wire logic csFaultIn,
  input wire logic sdOtpIn,
  input wire logic sdOvpIn,
  input wire logic dieHotIn,
  input wire logic sdFoldbackIn,
  input wire logic dimZeroIn,
  input wire logic dimFullIn,
  input wire logic supplyOnIn,
  input wire logic supplyOkIn,
  input wire logic lineHighIn,
  input wire logic lightLoadIn,
  input wire logic compSinkIn,
  output logic gateOn,
  output logic compGround,
  output logic compBoost,
  output logic refFull,
  output logic [3:0] refScale,
  output logic [2:0] valleyIndex,
  output logic faultLatched,
  output logic recovering
);

  typedef struct packed {
    logic [led_sup_pkg::NIN-1:0] s1;
    logic [led_sup_pkg::NIN-1:0] s2;
    logic [led_sup_pkg::NIN-1:0] s3;
    logic [led_sup_pkg::NIN-1:0] filt;
    led_sup_pkg::state_t state;
    logic gate;
    logic compGnd;
    logic boost;
    logic started;
    logic latchMode;
    logic modeCaught;
    logic [led_sup_pkg::REC_W-1:0] recCnt;
    logic [led_sup_pkg::AUX_W-1:0] auxCnt;
    logic [led_sup_pkg::TIMO_W-1:0] timoCnt;
    logic [led_sup_pkg::FOLD_W-1:0] foldCnt;
    logic [2:0] ocCnt;
    logic ocSeen;
    logic [2:0] valleyCnt;
    logic [2:0] valleyTarget;
    logic lockLine;
    logic lockLight;
    logic [3:0] scale;
    logic refFull;
    logic latched;
    logic recov;
  } sup_t;

  sup_t q, d;
  logic [led_sup_pkg::NIN-1:0] rawIn;
  logic [led_sup_pkg::NIN-1:0] f;
  logic valleyEdge;
  logic timeout;
  logic valleyTick;
  logic auxExpire;
  logic ocTrip;
  logic majorFault;
  logic onEnd;

  function automatic led_sup_pkg::state_t faultDest(input logic latchMode);
    faultDest = latchMode ? led_sup_pkg::ST_LATCH : led_sup_pkg::ST_RECOVER;
  endfunction : faultDest

  function automatic logic [2:0] valleyFor(input logic line,
                                           input logic light);
    valleyFor = (line ? led_sup_pkg::VALLEY_HIGH_LINE
                      : led_sup_pkg::VALLEY_LOW_LINE)
              + (light ? led_sup_pkg::VALLEY_LIGHT_ADD : 3'h0);
  endfunction : valleyFor

  ////////////////////////////////////////////////////////////////////////////
  // input gathering, highest index first
  assign rawIn = {compSinkIn, lightLoadIn, lineHighIn, supplyOkIn,
                  supplyOnIn, dimFullIn, dimZeroIn, sdFoldbackIn, dieHotIn,
                  sdOvpIn, sdOtpIn, csFaultIn, supplyOvpIn, valleyShortIn,
                  valleyLowIn, setpointTripIn, overCurrentIn, peakLimitIn};

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    f = q.filt;
    valleyEdge = 1'b0;
    timeout = 1'b0;
    valleyTick = 1'b0;
    auxExpire = 1'b0;
    ocTrip = 1'b0;
    majorFault = 1'b0;
    onEnd = 1'b0;
    if (ce) begin
      d.s1 = rawIn;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.filt = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));
      f = q.filt;
      if (!q.modeCaught) begin
        d.latchMode = versionLatchIn; // RL24
        d.modeCaught = 1'b1;
      end
      // thermal foldback ramp
      d.foldCnt = q.foldCnt + 1'b1;
      if (q.foldCnt == led_sup_pkg::FOLD_W'(led_sup_pkg::FOLD_STEP_CYCLES - 1))
      begin
        d.foldCnt = '0;
        if (f[led_sup_pkg::I_FOLD] && q.scale > led_sup_pkg::REF_MIN) begin
          d.scale = q.scale - 4'h1; // RL10
        end else if (!f[led_sup_pkg::I_FOLD] &&
                     q.scale < led_sup_pkg::REF_FULL) begin
          d.scale = q.scale + 4'h1;
        end
      end
      d.refFull = (d.scale == led_sup_pkg::REF_FULL) && // RL11
                  !f[led_sup_pkg::I_FOLD] && f[led_sup_pkg::I_DIMF];
      // valley lock
      if (f[led_sup_pkg::I_LINEH] != q.lockLine ||
          f[led_sup_pkg::I_LIGHT] != q.lockLight) begin
        d.lockLine = f[led_sup_pkg::I_LINEH]; // RL18
        d.lockLight = f[led_sup_pkg::I_LIGHT];
        d.valleyTarget = valleyFor(f[led_sup_pkg::I_LINEH], // RL17 RL21
                                   f[led_sup_pkg::I_LIGHT]);
      end
      valleyEdge = d.filt[led_sup_pkg::I_VLOW] & ~q.filt[led_sup_pkg::I_VLOW];
      timeout = q.timoCnt ==
                led_sup_pkg::TIMO_W'(led_sup_pkg::TIMO_CYCLES - 1); // RL19
      valleyTick = valleyEdge | timeout;
      auxExpire = q.auxCnt == led_sup_pkg::AUX_W'(AUX_CYCLES - 1);
      onEnd = (q.state == led_sup_pkg::ST_ON) &&
              (f[led_sup_pkg::I_PEAK] || f[led_sup_pkg::I_SETP]); // RL1 RL12
      ocTrip = onEnd && (q.ocSeen || f[led_sup_pkg::I_OC]) &&
               (q.ocCnt + 3'h1 >= led_sup_pkg::OC_LIMIT); // RL2
      majorFault = f[led_sup_pkg::I_OTP] || f[led_sup_pkg::I_SDOVP] || // RL9
                   f[led_sup_pkg::I_HOT] || // RL3
                   f[led_sup_pkg::I_CSFLT] || // RL8
                   auxExpire || ocTrip; // RL4
      if (q.boost && f[led_sup_pkg::I_SINK]) begin
        d.boost = 1'b0; // RL15
      end
      case (q.state)
        led_sup_pkg::ST_OFF: begin
          d.timoCnt = '0;
          if (f[led_sup_pkg::I_VCCON]) begin
            d.state = led_sup_pkg::ST_WAIT;
            d.boost = !q.started; // RL15 RL16
            d.started = 1'b1;
          end
        end
        led_sup_pkg::ST_WAIT, led_sup_pkg::ST_ON: begin
          if (f[led_sup_pkg::I_VSHORT]) begin
            d.auxCnt = '0; // RL20
          end else begin
            d.auxCnt = q.auxCnt + 1'b1; // RL6
          end
          if (q.state == led_sup_pkg::ST_ON) begin
            d.ocSeen = q.ocSeen | f[led_sup_pkg::I_OC];
            if (onEnd) begin
              d.state = led_sup_pkg::ST_WAIT;
              d.ocSeen = 1'b0;
              d.ocCnt = (q.ocSeen || f[led_sup_pkg::I_OC]) ?
                        q.ocCnt + 3'h1 : 3'h0; // RL2
            end
          end else begin
            d.timoCnt = valleyTick ? '0 : q.timoCnt + 1'b1;
            if (valleyTick) begin
              d.valleyCnt = q.valleyCnt + 3'h1;
              if (q.valleyCnt + 3'h1 >= q.valleyTarget) begin
                d.valleyCnt = '0;
                if (!f[led_sup_pkg::I_DIMZ]) begin
                  d.state = led_sup_pkg::ST_ON; // RL22
                end
              end
            end
          end
          if (!f[led_sup_pkg::I_VCCOK]) begin
            d.state = led_sup_pkg::ST_OFF; // RL13 RL16
          end else if (majorFault) begin
            d.state = faultDest(q.latchMode); // RL3 RL5
          end else if (f[led_sup_pkg::I_VCCOVP]) begin
            d.state = led_sup_pkg::ST_RECOVER; // RL7
          end
          if (d.state != q.state) begin
            d.valleyCnt = '0;
            d.ocSeen = 1'b0;
          end
          if (d.state == led_sup_pkg::ST_RECOVER ||
              d.state == led_sup_pkg::ST_LATCH) begin
            d.started = 1'b0;
            d.boost = 1'b0;
            d.auxCnt = '0;
            d.ocCnt = '0;
            d.recCnt = '0;
          end
        end
        led_sup_pkg::ST_RECOVER: begin
          d.recCnt = q.recCnt + 1'b1;
          if (q.recCnt == led_sup_pkg::REC_W'(REC_CYCLES - 1)) begin
            d.state = led_sup_pkg::ST_OFF; // RL3 RL7 RL23
          end
        end
        led_sup_pkg::ST_LATCH: begin
          d.state = led_sup_pkg::ST_LATCH; // RL23
        end
        default: begin
          d.state = led_sup_pkg::ST_OFF;
        end
      endcase
      d.gate = d.state == led_sup_pkg::ST_ON;
      d.compGnd = (d.state == led_sup_pkg::ST_OFF && !d.started) || // RL14
                  d.state == led_sup_pkg::ST_RECOVER ||
                  d.state == led_sup_pkg::ST_LATCH; // RL13
      d.latched = d.state == led_sup_pkg::ST_LATCH;
      d.recov = d.state == led_sup_pkg::ST_RECOVER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.state <= led_sup_pkg::ST_OFF;
      q.compGnd <= 1'b1;
      q.scale <= led_sup_pkg::REF_FULL;
      q.valleyTarget <= led_sup_pkg::VALLEY_LOW_LINE;
    end else begin
      q <= d;
    end
  end

  assign gateOn = q.gate;
  assign compGround = q.compGnd;
  assign compBoost = q.boost;
  assign refFull = q.refFull;
  assign refScale = q.scale;
  assign valleyIndex = q.valleyTarget;
  assign faultLatched = q.latched;
  assign recovering = q.recov;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  property p_peakOff;
    ce && q.state == led_sup_pkg::ST_ON && q.filt[led_sup_pkg::I_PEAK]
    |=> !gateOn;
  endproperty
  a_peakOff: assert property (p_peakOff) else $error("gate stayed on"); // RL1
  property p_ocStop;
    ce && ocTrip && q.filt[led_sup_pkg::I_VCCOK]
    |=> (recovering || faultLatched) && !gateOn;
  endproperty
  a_ocStop: assert property (p_ocStop) else $error("overcurrent missed"); // RL2
  property p_auxFault;
    ce && auxExpire && q.filt[led_sup_pkg::I_VCCOK] &&
    (q.state == led_sup_pkg::ST_WAIT || q.state == led_sup_pkg::ST_ON)
    |=> recovering != faultLatched;
  endproperty
  a_auxFault: assert property (p_auxFault) else $error("aux short"); // RL4
  property p_latchHold;
    faultLatched |=> faultLatched && compGround && !gateOn;
  endproperty
  a_latchHold: assert property (p_latchHold) else $error("latch lost"); // RL23
  property p_faultGround;
    (recovering || faultLatched) |-> compGround && !compBoost;
  endproperty
  a_faultGround: assert property (p_faultGround) else $error("comp"); // RL13
  property p_uvloKeep;
    ce && !q.filt[led_sup_pkg::I_VCCOK] &&
    (q.state == led_sup_pkg::ST_WAIT || q.state == led_sup_pkg::ST_ON)
    |=> !compGround && !gateOn && !recovering;
  endproperty
  a_uvloKeep: assert property (p_uvloKeep) else $error("undervoltage_lockout comp"); // RL16
  property p_dimOff;
    ce && q.state == led_sup_pkg::ST_WAIT && q.filt[led_sup_pkg::I_DIMZ]
    |=> !gateOn;
  endproperty
  a_dimOff: assert property (p_dimOff) else $error("dim zero gate"); // RL22
  property p_boostEnd;
    ce && compBoost && q.filt[led_sup_pkg::I_SINK] |=> !compBoost;
  endproperty
  a_boostEnd: assert property (p_boostEnd) else $error("boost stuck"); // RL15
  property p_foldFloor;
    refScale >= led_sup_pkg::REF_MIN && (refFull -> refScale == 4'hf);
  endproperty
  a_foldFloor: assert property (p_foldFloor) else $error("ref floor"); // RL10
  property p_timeout;
    ce && q.state == led_sup_pkg::ST_WAIT && timeout |=> q.timoCnt == '0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout"); // RL19

  c_start: cover property ($rose(gateOn));
  c_recover: cover property ($fell(recovering));
  c_latch: cover property ($rose(faultLatched));
  c_fold: cover property (refScale == led_sup_pkg::REF_MIN);

endmodule : led_driver_fault_startup_supervisor

// ==== tb/power_stage_model.sv ====
// comparator and power stage model facing the supervisor
`timescale 1ns/1ps
module power_stage_model #(
  parameter int ON_LEN = 12,
  parameter int OFF_LEN = 8
) (
  input wire logic clock,
  input wire logic gateOn,
  input wire logic [1:0] stageMode,
  output logic setpointTripIn,
  output logic valleyLowIn,
  output logic valleyShortIn
);
  logic [7:0] cnt;
  logic gatePrev;
  initial begin
    cnt = 8'h00;
    gatePrev = 1'b0;
    setpointTripIn = 1'b0;
    valleyLowIn = 1'b0;
    valleyShortIn = 1'b0;
  end
  // mode 0 normal, 1 shorted aux winding, 2 damped ringing
  always @(posedge clock) begin
    gatePrev <= gateOn;
    cnt <= (gateOn != gatePrev) ? 8'h00 : cnt + 8'h01;
    setpointTripIn <= gateOn && cnt >= 8'(ON_LEN);
    valleyShortIn <= !gateOn && stageMode == 2'h0 && cnt < 8'h04;
    valleyLowIn <= !gateOn && stageMode != 2'h2 && cnt >= 8'(OFF_LEN)
      && cnt[2];
  end
endmodule : power_stage_model

// ==== tb/testbench.sv ====
// self-checking bench for the led driver supervisor
`timescale 1ns/1ps
module testbench;
  localparam int REC = 50;
  localparam int AUX = 400;
  logic clock, arst_n, versionLatchIn, peakLimitIn, overCurrentIn;
  logic supplyOvpIn, dimZeroIn, dimFullIn, supplyOnIn, supplyOkIn;
  logic lineHighIn, lightLoadIn, compSinkIn, sdFoldbackIn, pg, ce;
  logic [3:0] faultVec;
  logic [1:0] stageMode;
  logic setpointTripIn, valleyLowIn, valleyShortIn;
  logic gateOn, compGround, compBoost, refFull, faultLatched, recovering;
  logic [3:0] refScale;
  logic [2:0] valleyIndex;
  int n_fail, checks, cycles, n, k, v;
  typedef struct packed {
    logic line; logic light; logic dimFull; logic [2:0] idx;
  } row_t;
  row_t rows [4] = '{'{1'b0, 1'b0, 1'b1, 3'h1}, '{1'b1, 1'b0, 1'b0, 3'h2},
    '{1'b1, 1'b1, 1'b1, 3'h3}, '{1'b0, 1'b1, 1'b0, 3'h2}};

  led_driver_fault_startup_supervisor #(.REC_CYCLES(REC),
    .AUX_CYCLES(AUX)) dut_u (.clock(clock), .arst_n(arst_n), .ce(ce),
    .versionLatchIn(versionLatchIn), .peakLimitIn(peakLimitIn),
    .overCurrentIn(overCurrentIn), .setpointTripIn(setpointTripIn),
    .valleyLowIn(valleyLowIn), .valleyShortIn(valleyShortIn),
    .supplyOvpIn(supplyOvpIn), .csFaultIn(faultVec[3]),
    .sdOtpIn(faultVec[0]), .sdOvpIn(faultVec[1]), .dieHotIn(faultVec[2]),
    .sdFoldbackIn(sdFoldbackIn), .dimZeroIn(dimZeroIn),
    .dimFullIn(dimFullIn), .supplyOnIn(supplyOnIn),
    .supplyOkIn(supplyOkIn), .lineHighIn(lineHighIn),
    .lightLoadIn(lightLoadIn), .compSinkIn(compSinkIn), .gateOn(gateOn),
    .compGround(compGround), .compBoost(compBoost), .refFull(refFull),
    .refScale(refScale), .valleyIndex(valleyIndex),
    .faultLatched(faultLatched), .recovering(recovering));
  power_stage_model stage_u (.clock(clock), .gateOn(gateOn),
    .stageMode(stageMode), .setpointTripIn(setpointTripIn),
    .valleyLowIn(valleyLowIn), .valleyShortIn(valleyShortIn));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [3:0] e,
      input logic [3:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {3'h0, e}, {3'h0, g});
  endtask : chkb
  function automatic logic pick(input int s);
    case (s)
      0: return gateOn;
      1: return recovering;
      default: return faultLatched;
    endcase
  endfunction : pick
  task automatic waitSig(input int s, input logic lvl, input int lim);
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : waitSig
  task automatic boot(input logic ver);
    arst_n = 1'b0;
    versionLatchIn = ver;
    ce = 1'b1;
    {peakLimitIn, overCurrentIn, supplyOvpIn, dimZeroIn} = 4'h0;
    {supplyOnIn, supplyOkIn, lineHighIn, lightLoadIn} = 4'h0;
    {compSinkIn, sdFoldbackIn, dimFullIn} = 3'h1;
    faultVec = 4'h0;
    stageMode = 2'h0;
    cyc(10);
    chkb("rst gate", 1'b0, gateOn);
    chkb("rst comp ground", 1'b1, compGround);
    chkb("rst boost", 1'b0, compBoost);
    chk("rst scale", 4'hf, refScale);
    chk("rst valley", 4'h1, {1'b0, valleyIndex});
    chkb("rst latched", 1'b0, faultLatched);
    chkb("rst recovering", 1'b0, recovering);
    arst_n = 1'b1;
    cyc(4);
    {supplyOnIn, supplyOkIn} = 2'h3;
    waitSig(0, 1'b1, 400);
    chkb("start gate", 1'b1, gateOn);
    chkb("start ground", 1'b0, compGround);
    chkb("start boost", 1'b1, compBoost);
  endtask : boot
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    n_fail = 0;
    checks = 0;
    cycles = 0;
    boot(1'b0);
    waitSig(0, 1'b0, 60);
    chkb("setpoint end", 1'b1, n <= 20);
    compSinkIn = 1'b1;
    cyc(8);
    chkb("boost off", 1'b0, compBoost);
    for (k = 0; k < 4; k++) begin
      {lineHighIn, lightLoadIn, dimFullIn} = rows[k][5:3];
      cyc(10);
      chk("valley", {1'b0, rows[k].idx}, {1'b0, valleyIndex});
      chkb("ref full", rows[k].dimFull, refFull);
    end
    {lineHighIn, lightLoadIn, dimFullIn} = 3'h1;
    waitSig(0, 1'b0, 60);
    waitSig(0, 1'b1, 100);
    peakLimitIn = 1'b1;
    waitSig(0, 1'b0, 20);
    chkb("peak cut", 1'b1, n <= 6);
    peakLimitIn = 1'b0;
    dimZeroIn = 1'b1;
    cyc(6);
    waitSig(0, 1'b1, 400);
    chkb("dim hold", 1'b1, n == 400);
    dimZeroIn = 1'b0;
    waitSig(0, 1'b1, 400);
    {supplyOnIn, supplyOkIn} = 2'h0;
    cyc(8);
    chkb("lockout gate", 1'b0, gateOn);
    chkb("lockout ground", 1'b0, compGround);
    {supplyOnIn, supplyOkIn} = 2'h3;
    waitSig(0, 1'b1, 100);
    chkb("retry", 1'b1, gateOn);
    chkb("retry ground", 1'b0, compGround);
    ce = 1'b0;
    cyc(40);
    chkb("ce freeze", 1'b1, gateOn);
    ce = 1'b1;
    supplyOvpIn = 1'b1;
    cyc(8);
    chkb("ovp rec", 1'b1, recovering);
    chkb("ovp ground", 1'b1, compGround);
    supplyOvpIn = 1'b0;
    waitSig(1, 1'b0, REC + 20);
    chkb("ovp length", 1'b1, n >= REC - 15 && n < REC + 20);
    waitSig(0, 1'b0, 400);
    overCurrentIn = 1'b1;
    k = 0;
    pg = 1'b0;
    for (n = 0; n < 400 && recovering !== 1'b1; n++) begin
      if (gateOn === 1'b1 && pg === 1'b0) k++;
      pg = gateOn;
      cyc(1);
    end
    chk("oc count", 4'h4, 4'(k));
    overCurrentIn = 1'b0;
    waitSig(1, 1'b0, REC + 20);
    cyc(AUX + 50);
    chkb("no aux trip", 1'b0, recovering);
    stageMode = 2'h1;
    waitSig(1, 1'b1, AUX + 60);
    chkb("aux trip", 1'b1, n >= AUX - 50 && n < AUX + 60);
    chkb("aux ground", 1'b1, compGround);
    stageMode = 2'h0;
    waitSig(0, 1'b1, 400);
    waitSig(0, 1'b0, 60);
    stageMode = 2'h2;
    waitSig(0, 1'b1, 320);
    chkb("timeout valley", 1'b1, n >= 200 && n < 320);
    stageMode = 2'h0;
    sdFoldbackIn = 1'b1;
    cyc(600);
    chkb("fold step", 1'b1, refScale < 4'hf && refScale > 4'h8);
    cyc(2000);
    chk("fold floor", 4'h8, refScale);
    chkb("fold ref", 1'b0, refFull);
    for (v = 0; v < 2; v++) begin
      for (k = 0; k < 5; k++) begin
        boot(v[0]);
        if (k < 4) faultVec[k] = 1'b1;
        else stageMode = 2'h1;
        if (k < 4) cyc(12);
        else waitSig(v ? 2 : 1, 1'b1, AUX + 60);
        chkb("fault state", 1'b1, v ? faultLatched : recovering);
        chkb("fault gate", 1'b0, gateOn);
        chkb("fault ground", 1'b1, compGround);
        faultVec = 4'h0;
        stageMode = 2'h0;
        cyc(REC + 50);
        chkb("latch hold", v[0], faultLatched);
        chkb("recovered", 1'b0, recovering);
      end
    end
    summarize();
  end
endmodule : testbench
